// >>> adc_result_regs.sv
// Converter control, result formatting and APB register slave
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/10ps
module adc_result_regs
  import adc_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  // Analog front end
  input  wire logic [9:0]  sample_code,
  output      logic        converter_on,
  output      logic [4:0]  channel_select,
  output      logic        conv_busy,
  // Interrupt
  output      logic        irq
);

  // Cycles per conversion clock period
  function automatic logic [CNT_W-1:0] tad_cycles(input logic [2:0] sel);
    logic [CNT_W-1:0] d;
    d = CNT_W'(FRC_DIV);
    unique case (sel)
      3'h0:    d = CNT_W'(2);
      3'h1:    d = CNT_W'(8);
      3'h2:    d = CNT_W'(32);
      3'h4:    d = CNT_W'(4);
      3'h5:    d = CNT_W'(16);
      3'h6:    d = CNT_W'(64);
      default: d = CNT_W'(FRC_DIV);
    endcase
    return d;
  endfunction : tad_cycles

  function automatic result_t format_result(input logic [9:0] code,
                                            input logic       right);
    result_t r;
    if (right) begin
      r.high = {6'h00, code[9:8]};          // see RL3, see RL8
      r.low  = code[7:0];                   // see RL4
    end else begin
      r.high = code[9:2];                   // see RL2
      r.low  = {code[1:0], 6'h00};          // see RL1, see RL8
    end
    return r;
  endfunction : format_result

  // State
  ctrl0_t           ctrl0_q, ctrl0_d;
  ctrl1_t           ctrl1_q, ctrl1_d;
  result_t          res_q, res_d;
  logic [1:0]       stat_q, stat_d;
  logic [1:0]       mask_q, mask_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [CNT_W-1:0] acq_q, acq_d;
  logic [31:0]      prdata_q, prdata_d;
  logic             pready_q, pready_d;
  logic             pslverr_q, pslverr_d;
  logic             irq_q, irq_d;

  logic             xfer;
  logic             wr;
  logic             conv_end;
  logic             acq_hit;
  logic [CNT_W-1:0] conv_len;
  ctrl0_t           wr0;

  // One wait state so every answer comes from a flip-flop
  assign xfer     = psel && penable && pready_q;
  assign wr       = xfer && pwrite;
  assign wr0      = ctrl0_t'(pwdata[7:0]);
  assign conv_len = CNT_W'(CONV_TAD) * tad_cycles(ctrl1_q.conv_clock_select);
  assign conv_end = ctrl0_q.go && (cnt_q == conv_len - CNT_W'(1));
  assign acq_hit  = (acq_q == CNT_W'(ACQ_CYCLES - 1));

  // Control, sequencing and events
  always_comb begin
    ctrl0_d = ctrl0_q;
    ctrl1_d = ctrl1_q;
    mask_d  = mask_q;
    stat_d  = stat_q;
    cnt_d   = ctrl0_q.go ? cnt_q + CNT_W'(1) : '0;
    acq_d   = acq_q;
    if (wr && paddr == ADDR_CTRL0) begin
      ctrl0_d.channel_select = wr0.channel_select;
      ctrl0_d.converter_on   = wr0.converter_on;
      // Clearing the bit while busy aborts with no result
      if (ctrl0_q.go) begin
        ctrl0_d.go = wr0.go;
      end else begin
        ctrl0_d.go = wr0.go && wr0.converter_on;         // see RL7
      end
      if (ctrl0_d.go && !ctrl0_q.go) begin
        cnt_d = '0;
      end
    end
    if (wr && paddr == ADDR_CTRL1) begin
      ctrl1_d      = ctrl1_t'(pwdata[7:0]);
      ctrl1_d.unused = 1'b0;
    end
    if (wr && paddr == ADDR_IRQ_MK) begin
      mask_d = pwdata[1:0];
    end
    if (wr && paddr == ADDR_IRQ_ST) begin
      stat_d = stat_q & ~pwdata[1:0];
    end
    if (conv_end) begin
      ctrl0_d.go = 1'b0;                                 // see RL7, see RL9
    end
    if (!ctrl0_d.converter_on) begin
      ctrl0_d.go = 1'b0;
    end
    // Acquisition timer restarts on any channel change
    if (!ctrl0_d.converter_on ||
        ctrl0_d.channel_select != ctrl0_q.channel_select ||
        ctrl0_q.go) begin
      acq_d = '0;                                        // see RL6
    end else if (acq_q != CNT_W'(ACQ_CYCLES)) begin
      // Parks at the full count so the ready bit stays up
      acq_d = acq_q + CNT_W'(1);
    end
    // Set wins over a clear in the same cycle
    if (conv_end) begin
      stat_d[IRQ_DONE] = 1'b1;
    end
    if (acq_hit && acq_d == CNT_W'(ACQ_CYCLES)) begin
      stat_d[IRQ_ACQ] = 1'b1;
    end
    ctrl0_d.unused = 1'b0;
    irq_d = |(stat_q & mask_q);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_q <= ctrl0_t'(CTRL0_RST);
      ctrl1_q <= ctrl1_t'(CTRL1_RST);
      stat_q  <= IRQ_RST;
      mask_q  <= IRQ_RST;
      cnt_q   <= '0;
      acq_q   <= '0;
      irq_q   <= 1'b0;
    end else begin
      ctrl0_q <= ctrl0_d;
      ctrl1_q <= ctrl1_d;
      stat_q  <= stat_d;
      mask_q  <= mask_d;
      cnt_q   <= cnt_d;
      acq_q   <= acq_d;
      irq_q   <= irq_d;
    end
  end

  // Results: hardware load wins over a software write
  always_comb begin
    res_d = res_q;
    if (wr && paddr == ADDR_RES_HI) begin
      res_d.high = pwdata[7:0];                          // see RL5
    end
    if (wr && paddr == ADDR_RES_LO) begin
      res_d.low = pwdata[7:0];                           // see RL5
    end
    if (conv_end) begin
      res_d = format_result(sample_code, ctrl1_q.justify_select); // see RL9
    end
  end

  // No reset: contents survive every reset, unknown at power-up
  always_ff @(posedge pclk) begin
    res_q <= res_d;                                      // see RL5
  end

  // APB answer path
  // Reads capture state in the cycle before the answer
  always_comb begin
    pready_d  = psel && penable && !pready_q;
    pslverr_d = 1'b0;
    prdata_d  = prdata_q;
    if (pready_d) begin
      prdata_d = '0;
      unique case (paddr)
        ADDR_CTRL0:  prdata_d[7:0] = ctrl0_q;
        ADDR_CTRL1:  prdata_d[7:0] = ctrl1_q;
        ADDR_RES_HI: prdata_d[7:0] = res_q.high;
        ADDR_RES_LO: prdata_d[7:0] = res_q.low;
        ADDR_STATE:  prdata_d[1:0] = {acq_q == CNT_W'(ACQ_CYCLES), ctrl0_q.go};
        ADDR_IRQ_ST: prdata_d[1:0] = stat_q;
        ADDR_IRQ_MK: prdata_d[1:0] = mask_q;
        default:     pslverr_d     = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata         = prdata_q;
  assign pready         = pready_q;
  assign pslverr        = pslverr_q;
  assign converter_on   = ctrl0_q.converter_on;
  assign channel_select = ctrl0_q.channel_select;
  assign conv_busy      = ctrl0_q.go;
  assign irq            = irq_q;

  // Checks
  chk_left_low: assert property (@(posedge pclk) disable iff (!presetn) // see RL1
    conv_end && !ctrl1_q.justify_select
      |=> res_q.low == {$past(sample_code[1:0]), 6'h00})
    else $error("left low result wrong");

  chk_left_high: assert property (@(posedge pclk) disable iff (!presetn) // see RL2
    conv_end && !ctrl1_q.justify_select
      |=> res_q.high == $past(sample_code[9:2]))
    else $error("left high result wrong");

  chk_right_high: assert property (@(posedge pclk) disable iff (!presetn) // see RL3
    conv_end && ctrl1_q.justify_select
      |=> res_q.high[1:0] == $past(sample_code[9:8]) && res_q.high[7:2] == 6'h00)
    else $error("right high result wrong");

  chk_right_low: assert property (@(posedge pclk) disable iff (!presetn) // see RL4
    conv_end && ctrl1_q.justify_select |=> res_q.low == $past(sample_code[7:0]))
    else $error("right low result wrong");

  chk_result_hold: assert property (@(posedge pclk) disable iff (!presetn) // see RL5
    !conv_end && !(wr && (paddr == ADDR_RES_HI || paddr == ADDR_RES_LO))
      |=> $stable(res_q))
    else $error("result changed with no cause");

  chk_go_clear: assert property (@(posedge pclk) disable iff (!presetn) // see RL7
    $rose(ctrl0_q.go) |-> ctrl0_q.go [*2] ##[0:720] !ctrl0_q.go)
    else $error("conversion did not finish in time");

  chk_same_cycle: assert property (@(posedge pclk) disable iff (!presetn) // see RL9
    conv_end |=> !ctrl0_q.go && stat_q[IRQ_DONE])
    else $error("end of conversion not reported");

  // Done event must reach the pin two edges after the load
  chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn) // see RL9
    conv_end && mask_q[IRQ_DONE] && !(wr && paddr == ADDR_IRQ_MK) |=> ##1 irq_q)
    else $error("done event raised no interrupt");

  // Software writes to the results land when no load competes
  chk_write_high: assert property (@(posedge pclk) disable iff (!presetn) // see RL5
    wr && paddr == ADDR_RES_HI && !conv_end |=> res_q.high == $past(pwdata[7:0]))
    else $error("result high write lost");

  chk_write_low: assert property (@(posedge pclk) disable iff (!presetn) // see RL5
    wr && paddr == ADDR_RES_LO && !conv_end |=> res_q.low == $past(pwdata[7:0]))
    else $error("result low write lost");

  // Reserved positions of the loaded word must read as zero
  chk_unused_zero: assert property (@(posedge pclk) disable iff (!presetn) // see RL8
    conv_end |=> ($past(ctrl1_q.justify_select) ? res_q.high[7:2] : res_q.low[5:0]) == 6'h00)
    else $error("unused result bits not zero");

  chk_start_busy: assert property (@(posedge pclk) disable iff (!presetn) // see RL7
    wr && paddr == ADDR_CTRL0 && wr0.go && wr0.converter_on && !ctrl0_q.go |=> ctrl0_q.go)
    else $error("start request not taken");

  chk_go_needs_on: assert property (@(posedge pclk) disable iff (!presetn) // see RL7
    ctrl0_q.go |-> ctrl0_q.converter_on)
    else $error("busy while converter off");

  chk_refuse_off: assert property (@(posedge pclk) disable iff (!presetn) // see RL7
    wr && paddr == ADDR_CTRL0 && !wr0.converter_on |=> !ctrl0_q.go)
    else $error("start taken with converter off");

  chk_go_hold: assert property (@(posedge pclk) disable iff (!presetn) // see RL7
    ctrl0_q.go && !conv_end && !(wr && paddr == ADDR_CTRL0) |=> ctrl0_q.go)
    else $error("busy dropped before the end");

  chk_busy_read: assert property (@(posedge pclk) disable iff (!presetn) // see RL7
    pready_d && paddr == ADDR_CTRL0 |=> prdata_q[1] == $past(ctrl0_q.go))
    else $error("status bit read wrong");

  // Any channel change must restart the acquisition wait
  chk_acq_restart: assert property (@(posedge pclk) disable iff (!presetn) // see RL6
    $changed(ctrl0_q.channel_select) |-> acq_q == CNT_W'(0))
    else $error("acquisition not restarted on channel change");

  chk_acq_off: assert property (@(posedge pclk) disable iff (!presetn) // see RL6
    !ctrl0_q.converter_on |-> acq_q == CNT_W'(0))
    else $error("acquisition counted while off");

endmodule : adc_result_regs

// >>> adc_pkg.sv
// Constants, field layouts and types for the converter register block
// Overview of operation
// RL1: Left mode: result bits 1-0 to low 7-6
// RL2: Left mode: result bits 9-2 to high
// RL3: Right mode: result bits 9-8 to high 1-0
// RL4: Right mode: result bits 7-0 to low
// RL5: Results read/write, untouched by reset
// RL6: Software waits acquisition time before start
// RL7: Start bit set by software, hardware clears
// RL8: Unused result bits forced to zero
// RL9: Results load with start bit clear
package adc_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL0  = 8'h00;
  localparam logic [7:0] ADDR_CTRL1  = 8'h04;
  localparam logic [7:0] ADDR_RES_HI = 8'h08;
  localparam logic [7:0] ADDR_RES_LO = 8'h0C;
  localparam logic [7:0] ADDR_STATE  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_ST = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MK = 8'h18;

  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [1:0] IRQ_RST   = 2'h0;

  // Event bits of status and mask
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ACQ  = 1;

  // Converter timing
  localparam int TACQ_NS     = 4970;
  localparam int CLK_NS      = 8;
  localparam int ACQ_CYCLES  = (TACQ_NS + CLK_NS - 1) / CLK_NS;
  localparam int CONV_TAD    = 11;
  localparam int FRC_DIV     = 4;
  localparam int CNT_W       = 10;

  typedef struct packed {
    logic       unused;
    logic [4:0] channel_select;
    logic       go;
    logic       converter_on;
  } ctrl0_t;

  typedef struct packed {
    logic       justify_select;
    logic [2:0] conv_clock_select;
    logic       unused;
    logic       neg_ref_select;
    logic [1:0] pos_ref_select;
  } ctrl1_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } result_t;

endpackage : adc_pkg

// >>> adc_result_register_formatting_tb_top.sv
// Self-checking bench for the converter result register block
`timescale 1ns/10ps
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, a); end end
module adc_result_register_formatting_tb_top;
  import adc_pkg::*;
  logic        pclk = 0;
  logic        presetn = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [9:0]  sample_code = '0;
  logic        converter_on;
  logic [4:0]  channel_select;
  logic        conv_busy;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          error_cnt = 0;
  int          n_checks = 0;
  int          cnt;

  always #4 pclk = ~pclk;

  adc_result_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_code(sample_code), .converter_on(converter_on),
    .channel_select(channel_select), .conv_busy(conv_busy), .irq(irq));

  // Holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= 32'(d);
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    `CHK("pready", 1'b1, pready)
  endtask : apb

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 8'h00);
    `CHK(nm, e, rd)
  endtask : rchk

  // One conversion; expectation built from the integer model
  task automatic convert(input int c, input logic j, input logic m, input logic [2:0] cs);
    int ch, hi, lo, tad;
    ch = $urandom % 12;
    hi = j ? c >> 8 : c >> 2;
    lo = j ? c & 255 : (c & 3) << 6;
    // Conversion clock divisor per select code
    case (cs)
      3'h0:    tad = 2;
      3'h1:    tad = 8;
      3'h2:    tad = 32;
      3'h4:    tad = 4;
      3'h5:    tad = 16;
      3'h6:    tad = 64;
      default: tad = FRC_DIV;
    endcase
    sample_code <= 10'(c);
    apb(1'b1, ADDR_IRQ_MK, {7'h00, m});
    apb(1'b1, ADDR_CTRL1, {j, cs, 4'h0});
    apb(1'b1, ADDR_RES_HI, 8'hff);
    apb(1'b1, ADDR_RES_LO, 8'hff);
    apb(1'b1, ADDR_CTRL0, 8'(ch * 4 + 1));
    // Acquisition must elapse before the start bit
    cnt = 0;
    do begin
      apb(1'b0, ADDR_STATE, 8'h00);
      cnt++;
    end while (rd[1] !== 1'b1 && cnt < 400);
    `CHK("acq_done", 1'b1, rd[1])
    `CHK("channel", 5'(ch), channel_select)
    `CHK("conv_on", 1'b1, converter_on)
    apb(1'b1, ADDR_CTRL0, 8'(ch * 4 + 3));
    #1;
    `CHK("busy_set", 1'b1, conv_busy)
    cnt = 0;
    while (conv_busy === 1'b1 && cnt < 1000) begin
      @(posedge pclk);
      #1;
      cnt++;
    end
    `CHK("conv_len", CONV_TAD * tad, cnt)
    rchk("busy_clr", ADDR_CTRL0, 32'(ch * 4 + 1));
    rchk("res_hi", ADDR_RES_HI, 32'(hi));
    rchk("res_lo", ADDR_RES_LO, 32'(lo));
    apb(1'b0, ADDR_IRQ_ST, 8'h00);
    `CHK("done_flag", 1'b1, rd[IRQ_DONE])
    `CHK("acq_flag", 1'b1, rd[IRQ_ACQ])
    `CHK("irq_mask", m, irq)
    apb(1'b1, ADDR_IRQ_ST, 8'h03);
    repeat (2) @(posedge pclk);
    `CHK("irq_clr", 1'b0, irq)
  endtask : convert

  task end_sim;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  initial begin
    #(8 * 40000);
    error_cnt++;
    $display("MISMATCH watchdog exp done got timeout");
    end_sim();
  end

  initial begin
    void'($urandom(32'h0000_f844));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rchk("ctrl0_rst", ADDR_CTRL0, 32'(CTRL0_RST));
    rchk("ctrl1_rst", ADDR_CTRL1, 32'(CTRL1_RST));
    // Unmapped place: refused, reads zero
    apb(1'b0, 8'h1c, 8'h00);
    `CHK("unmap_err", 1'b1, err)
    `CHK("unmap_rd", 32'h0000_0000, rd)
    // Start with the converter off is refused
    apb(1'b1, ADDR_CTRL0, 8'h02);
    rchk("start_off", ADDR_CTRL0, 32'h0000_0000);
    // Results survive a reset other than power-up
    apb(1'b1, ADDR_RES_HI, 8'h5a);
    apb(1'b1, ADDR_RES_LO, 8'ha5);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk("keep_hi", ADDR_RES_HI, 32'h0000_005a);
    rchk("keep_lo", ADDR_RES_LO, 32'h0000_00a5);
    // Boundary codes then random ones, both justifications
    convert(10'h3ff, 1'b0, 1'b1, 3'h0);
    convert(10'h3ff, 1'b1, 1'b0, 3'h7);
    convert(10'h000, 1'b0, 1'b0, 3'h3);
    for (int i = 0; i < 6; i++) begin
      convert($urandom % 1024, i[0], i[1], 3'(i + 1));
    end
    end_sim();
  end
endmodule : adc_result_register_formatting_tb_top
